//--- async_serial_transceiver.sv
// async_serial_transceiver: axi4-lite register slave, baud generator,
// asynchronous transmitter and sixteen-times oversampling receiver.
// assumes rx_in is synchronous to aclk and the pad resolves tx_out/tx_oe.
//
// Added by the designer: register access over AXI4-Lite and the placing of the registers.
`include "serial_consts.svh"
`default_nettype none

module async_serial_transceiver (
   input wire logic aclk, // system clock, 50 mhz
   input wire logic aresetn, // synchronous reset, active low
   input wire logic awvalid, // write address valid
   output logic awready, // write address ready
   input wire logic [7:0] awaddr, // write byte address
   input wire logic wvalid, // write data valid
   output logic wready, // write data ready
   input wire logic [31:0] wdata, // write data
   input wire logic [3:0] wstrb, // write byte strobes
   output logic bvalid, // write response valid
   input wire logic bready, // write response ready
   output logic [1:0] bresp, // write response code
   input wire logic arvalid, // read address valid
   output logic arready, // read address ready
   input wire logic [7:0] araddr, // read byte address
   output logic rvalid, // read data valid
   input wire logic rready, // read data ready
   output logic [31:0] rdata, // read data
   output logic [1:0] rresp, // read response code
   output logic tx_out, // transmit pin level
   output logic tx_oe, // transmit pin driven
   input wire logic rx_in // receive pin level
);
   import serial_pkg::*;
   core_state_t st_q, st_d;
   fifo_if f ();
   logic tick, tx_act, rx_on, rx_act, tend, rend, load, maj, tval, push_req;
   logic wr_en, wr_tx, rd_en;
   logic [15:0] limit;
   logic [3:0] tlast, rlast;
   logic [5:0] widx, ridx;
   logic [31:0] rword;

   rx_fifo_mem store (
      .aclk(aclk),
      .aresetn(aresetn),
      .f(f)
   );

   always_comb begin
      st_d = st_q;
      // bus slave: address and data are latched independently
      widx = st_q.awaddr[7:2];
      ridx = araddr[7:2];
      awready = !st_q.aw_got;
      wready = !st_q.w_got;
      arready = !st_q.rvalid;
      if (awvalid && !st_q.aw_got) begin
         st_d.aw_got = 1'b1;
         st_d.awaddr = awaddr;
      end
      if (wvalid && !st_q.w_got) begin
         st_d.w_got = 1'b1;
         st_d.wdata = wdata;
         st_d.wstrb = wstrb;
      end
      tx_act = st_q.ctrl[`CB_PORT_EN] && st_q.ctrl[`CB_TX_EN] && !st_q.ctrl[`CB_SYNC];
      rx_on = st_q.ctrl[`CB_PORT_EN] && st_q.ctrl[`CB_RX_EN] && !st_q.ctrl[`CB_SYNC];
      rx_act = rx_on && !st_q.ovr;
      // a pending response blocks the next write so no answer is lost
      wr_en = st_q.aw_got && st_q.w_got && !st_q.bvalid;
      wr_tx = wr_en && (widx == `IDX_TXD) && st_q.wstrb[0] && tx_act;
      if (wr_en) begin
         st_d.aw_got = 1'b0;
         st_d.w_got = 1'b0;
         st_d.bvalid = 1'b1;
         st_d.bresp = (widx <= `IDX_BAUD) ? `RESP_OK : `RESP_ERR;
         if (widx == `IDX_CTRL && st_q.wstrb[0]) begin
            st_d.ctrl[7:0] = st_q.wdata[7:0];
         end
         if (widx == `IDX_CTRL && st_q.wstrb[1]) begin
            st_d.ctrl[`CB_WIDE] = st_q.wdata[`CB_WIDE];
         end
         if (widx == `IDX_BAUD && st_q.wstrb[0]) begin
            st_d.div[7:0] = st_q.wdata[7:0];
         end
         if (widx == `IDX_BAUD && st_q.wstrb[1]) begin
            st_d.div[15:8] = st_q.wdata[15:8];
         end
      end
      if (st_q.bvalid && bready) begin
         st_d.bvalid = 1'b0;
      end
      // read mux; status is live state, rx word is the registered top
      case (ridx)
         `IDX_CTRL: rword = {23'h000000, st_q.ctrl};
         `IDX_STAT: rword = {26'h0000000, f.top[8], (f.count != '0) && f.top[9], st_q.ovr,
            rx_on && (f.count != '0), st_q.ts == T_IDLE, st_q.tbe};
         `IDX_RXD: rword = {24'h000000, f.top[7:0]};
         `IDX_BAUD: rword = {16'h0000, st_q.div};
         default: rword = '0;
      endcase
      rd_en = arvalid && !st_q.rvalid;
      if (rd_en) begin
         st_d.rvalid = 1'b1;
         st_d.rdata = rword;
         st_d.rresp = (ridx <= `IDX_BAUD) ? `RESP_OK : `RESP_ERR;
      end
      if (st_q.rvalid && rready) begin
         st_d.rvalid = 1'b0;
      end
      // reading the data word advances the fifo
      f.pop = rd_en && (ridx == `IDX_RXD) && (f.count != '0);
      // divisor of 8 or 16 bits makes the oversampling tick
      limit = st_q.ctrl[`CB_WIDE] ? st_q.div : {8'h00, st_q.div[7:0]};
      tick = st_q.ctrl[`CB_PORT_EN] && (st_q.bcnt == limit);
      st_d.bcnt = (tick || !st_q.ctrl[`CB_PORT_EN]) ? '0 : st_q.bcnt + 16'h0001;
      // transmitter: sixteen ticks per bit, shared with the receiver
      tlast = st_q.ctrl[`CB_TX_NINE] ? `BIT_LAST9 : `BIT_LAST8;
      tend = tick && (st_q.tcnt == `OVS_LAST);
      if (tick) begin
         st_d.tcnt = st_q.tcnt + 4'h1;
      end
      case (st_q.ts)
         T_START: begin
            if (tend) begin
               st_d.ts = T_DATA;
               st_d.tbit = '0;
            end
         end
         T_DATA: begin
            if (tend) begin
               st_d.tshift = {1'b0, st_q.tshift[8:1]};
               st_d.tbit = st_q.tbit + 4'h1;
               if (st_q.tbit == tlast) begin
                  st_d.ts = T_STOP;
               end
            end
         end
         T_STOP: begin
            if (tend) begin
               st_d.ts = T_IDLE;
            end
         end
         default: st_d.ts = st_q.ts;
      endcase
      // load at stop end or from idle
      load = st_q.buf_full && ((st_q.ts == T_IDLE) || (st_q.ts == T_STOP && tend));
      if (load) begin
         st_d.ts = T_START;
         st_d.tshift = st_q.tbuf;
         st_d.tcnt = '0;
         st_d.buf_full = 1'b0;
      end
      // ninth bit joins the byte on the write
      if (wr_tx) begin
         st_d.tbuf = {st_q.ctrl[`CB_TX_NINTH], st_q.wdata[7:0]};
         st_d.buf_full = 1'b1;
      end
      if (!tx_act) begin
         st_d.ts = T_IDLE;
         st_d.buf_full = 1'b0;
         st_d.tcnt = '0;
      end
      // flag lags the buffer by one register stage
      st_d.tbe = tx_act && !(st_q.buf_full && st_q.ts != T_IDLE);
      // line level from the next state, so idle is mark at once
      case (st_d.ts)
         T_START: tval = 1'b0;
         T_DATA: tval = st_d.tshift[0];
         default: tval = 1'b1;
      endcase
      st_d.tx_line = tval ^ st_d.ctrl[`CB_INV];
      // receiver: majority of three samples around mid bit
      rlast = st_q.ctrl[`CB_RX9] ? `BIT_LAST9 : `BIT_LAST8;
      maj = (st_q.vote[0] && st_q.vote[1]) || (st_q.vote[0] && rx_in)
         || (st_q.vote[1] && rx_in);
      rend = tick && (st_q.rcnt == `VOTE_C);
      push_req = 1'b0;
      if (tick && st_q.rs != R_IDLE) begin
         st_d.rcnt = st_q.rcnt + 4'h1;
         if (st_q.rcnt == `VOTE_A) begin
            st_d.vote[0] = rx_in;
         end
         if (st_q.rcnt == `VOTE_B) begin
            st_d.vote[1] = rx_in;
         end
      end
      case (st_q.rs)
         R_IDLE: begin
            if (tick) begin
               st_d.rx_prev = rx_in;
               if (st_q.rx_prev && !rx_in) begin
                  st_d.rs = R_START;
                  st_d.rcnt = '0;
               end
            end
         end
         R_START: begin
            if (rend && maj) begin
               st_d.rs = R_IDLE;
               st_d.rx_prev = 1'b1;
            end else if (rend) begin
               st_d.rs = R_DATA;
               st_d.rbit = '0;
            end
         end
         R_DATA: begin
            if (rend) begin
               st_d.rshift = {maj, st_q.rshift[8:1]};
               st_d.rbit = st_q.rbit + 4'h1;
               if (st_q.rbit == rlast) begin
                  st_d.rs = R_STOP;
               end
            end
         end
         R_STOP: begin
            // idle early at mid stop so a new start edge is not missed
            if (rend) begin
               st_d.rs = R_IDLE;
               st_d.rx_prev = maj;
               push_req = 1'b1;
            end
         end
         default: st_d.rs = R_IDLE;
      endcase
      // character and its framing error enter the fifo
      f.wdata = st_q.ctrl[`CB_RX9] ? {!maj, st_q.rshift} : {!maj, 1'b0, st_q.rshift[8:1]};
      f.push = push_req && (f.count != `FIFO_FULL);
      // overrun on a full fifo, halts via rx_act
      if (push_req && f.count == `FIFO_FULL) begin
         st_d.ovr = 1'b1;
      end
      if (!rx_act) begin
         st_d.rs = R_IDLE;
         st_d.rx_prev = 1'b1;
      end
      // overrun cleared by receive or port disable
      if (!st_q.ctrl[`CB_PORT_EN] || !st_q.ctrl[`CB_RX_EN]) begin
         st_d.ovr = 1'b0;
      end
      f.clear = !st_q.ctrl[`CB_PORT_EN];
   end

   // state register; the line rests at mark out of reset
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st_q <= '0;
         st_q.div <= `DIV_RST;
         st_q.tx_line <= 1'b1;
         st_q.rx_prev <= 1'b1;
      end else begin
         st_q <= st_d;
      end
   end

   assign bvalid = st_q.bvalid;
   assign bresp = st_q.bresp;
   assign rvalid = st_q.rvalid;
   assign rdata = st_q.rdata;
   assign rresp = st_q.rresp;
   assign tx_out = st_q.tx_line;
   assign tx_oe = st_q.ctrl[`CB_PORT_EN];

   property p_idle_mark;
      @(posedge aclk) disable iff (!aresetn)
      st_q.ts == T_IDLE |-> tx_out == !st_q.ctrl[`CB_INV];
   endproperty
   a_idle_mark: assert property (p_idle_mark) else $error("line not at mark in idle");

   property p_tx_gate;
      @(posedge aclk) disable iff (!aresetn)
      !tx_act |=> (st_q.ts == T_IDLE) && !st_q.buf_full;
   endproperty
   a_tx_gate: assert property (p_tx_gate) else $error("transmitter ran while disabled");

   property p_load_now;
      @(posedge aclk) disable iff (!aresetn)
      (st_q.ts == T_IDLE) && st_q.buf_full && tx_act |=> (st_q.ts == T_START)
         && (st_q.tcnt == '0) && !st_q.tx_line == !st_q.ctrl[`CB_INV];
   endproperty
   a_load_now: assert property (p_load_now) else $error("buffer not moved to shifter");

   property p_chain;
      @(posedge aclk) disable iff (!aresetn)
      (st_q.ts == T_STOP) && tend && st_q.buf_full && tx_act |=> st_q.ts == T_START;
   endproperty
   a_chain: assert property (p_chain) else $error("queued character not started");

   property p_tbe_delay;
      @(posedge aclk) disable iff (!aresetn)
      wr_tx && (st_q.ts == T_START || st_q.ts == T_DATA) && !st_q.buf_full
         |=> st_q.tbe ##1 !st_q.tbe;
   endproperty
   a_tbe_delay: assert property (p_tbe_delay) else $error("buffer flag timing wrong");

   property p_false_start;
      @(posedge aclk) disable iff (!aresetn)
      (st_q.rs == R_START) && rend && maj && rx_act && !f.pop |=> (st_q.rs == R_IDLE)
         && $stable(f.count) && !st_q.ovr;
   endproperty
   a_false_start: assert property (p_false_start) else $error("false start not dropped");

   property p_overrun;
      @(posedge aclk) disable iff (!aresetn)
      (st_q.rs == R_STOP) && rend && rx_act && (f.count == `FIFO_FULL) && !f.pop
         |=> st_q.ovr ##1 (st_q.rs == R_IDLE);
   endproperty
   a_overrun: assert property (p_overrun) else $error("overrun not flagged");

   property p_port_off;
      @(posedge aclk) disable iff (!aresetn)
      !st_q.ctrl[`CB_PORT_EN] |=> (f.count == '0) && !st_q.ovr && (st_q.ts == T_IDLE)
         && (st_q.rs == R_IDLE);
   endproperty
   a_port_off: assert property (p_port_off) else $error("port disable left state");
endmodule // async_serial_transceiver
`default_nettype wire

//--- serial_consts.svh
// serial_consts.svh: register map, control and status bit positions,
// oversampling counts and reset values of the asynchronous transceiver.
// assumes it is included once per compilation unit by its bare name.
`ifndef SERIAL_CONSTS_SVH
`define SERIAL_CONSTS_SVH
// register word indices; byte address is four times the index
`define IDX_CTRL 6'h00
`define IDX_STAT 6'h01
`define IDX_TXD 6'h02
`define IDX_RXD 6'h03
`define IDX_BAUD 6'h04
// control register bits
`define CB_PORT_EN 0
`define CB_TX_EN 1
`define CB_RX_EN 2
`define CB_SYNC 3
`define CB_TX_NINE 4
`define CB_RX9 5
`define CB_INV 6
`define CB_TX_NINTH 7
`define CB_WIDE 8
`define CTRL_W 9
// status register bits
`define SB_TBE 0
`define SB_SHE 1
`define SB_PEND 2
`define SB_OVR 3
`define SB_FRM_ERR 4
`define SB_RX9D 5
// oversampling: sixteen ticks per bit, votes on ticks 7, 8 and 9
`define OVS_LAST 4'hf
`define VOTE_A 4'h7
`define VOTE_B 4'h8
`define VOTE_C 4'h9
`define BIT_LAST8 4'h7
`define BIT_LAST9 4'h8
`define FIFO_FULL 2'h2
`define DIV_RST 16'h001f
`define RESP_OK 2'h0
`define RESP_ERR 2'h2
`endif

//--- serial_pkg.sv
// serial_pkg: state encodings and state records of the transceiver.
// assumes nothing beyond a sv-2012 compiler.
`default_nettype none
package serial_pkg;
   typedef enum logic [1:0] {T_IDLE = 2'b00, T_START = 2'b01, T_DATA = 2'b10,
      T_STOP = 2'b11} tx_state_t;
   typedef enum logic [1:0] {R_IDLE = 2'b00, R_START = 2'b01, R_DATA = 2'b10,
      R_STOP = 2'b11} rx_state_t;
   // fifo word: framing error, ninth bit, eight data bits
   typedef logic [9:0] fifo_word_t;
   typedef struct packed {
      logic [8:0] ctrl;
      logic [15:0] div;
      logic [15:0] bcnt;
      tx_state_t ts;
      logic [3:0] tcnt;
      logic [3:0] tbit;
      logic [8:0] tshift;
      logic [8:0] tbuf;
      logic buf_full;
      logic tbe;
      logic tx_line;
      rx_state_t rs;
      logic [3:0] rcnt;
      logic [3:0] rbit;
      logic [8:0] rshift;
      logic [1:0] vote;
      logic rx_prev;
      logic ovr;
      logic aw_got;
      logic w_got;
      logic [7:0] awaddr;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } core_state_t;
   typedef struct packed {
      fifo_word_t [1:0] mem;
      logic wp;
      logic rp;
      logic [1:0] cnt;
      fifo_word_t top;
   } fifo_state_t;
endpackage
`default_nettype wire

//--- fifo_if.sv
// fifo_if: push, pop and top-of-queue signals between the receiver and its
// two-entry character store. assumes serial_pkg is compiled first.
`default_nettype none
interface fifo_if;
   import serial_pkg::*;
   logic push;
   logic pop;
   logic clear;
   fifo_word_t wdata;
   logic [1:0] count;
   fifo_word_t top;
   modport mem (input push, input pop, input clear, input wdata, output count, output top);
   modport user (output push, output pop, output clear, output wdata, input count, input top);
endinterface
`default_nettype wire

//--- rx_fifo_mem.sv
// rx_fifo_mem: two-character receive store with a registered top word.
// assumes the user never pushes when full nor pops when empty.
`include "serial_consts.svh"
`default_nettype none
module rx_fifo_mem (
   input wire logic aclk, // system clock
   input wire logic aresetn, // synchronous reset, active low
   fifo_if.mem f // store port
);
   import serial_pkg::*;
   fifo_state_t s_q, s_d;

   // pointers toggle, the top word is taken from the next state
   always_comb begin
      s_d = s_q;
      if (f.clear) begin
         s_d.cnt = '0;
         s_d.wp = 1'b0;
         s_d.rp = 1'b0;
      end else begin
         if (f.push) begin
            s_d.mem[s_q.wp] = f.wdata;
            s_d.wp = ~s_q.wp;
         end
         if (f.pop) begin
            s_d.rp = ~s_q.rp;
         end
         s_d.cnt = s_q.cnt + {1'b0, f.push} - {1'b0, f.pop};
      end
      s_d.top = (s_d.cnt != '0) ? s_d.mem[s_d.rp] : '0;
   end

   // state register
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign f.count = s_q.cnt;
   assign f.top = s_q.top;
endmodule // rx_fifo_mem
`default_nettype wire

//--- serial_remote.sv
// serial_remote: far-end serial node; drives the device receive pin and
// decodes the device transmit pin. assumes one aclk domain, BIT clocks a bit.
`default_nettype none
module serial_remote #(
   parameter int BIT = 64 // clocks per serial bit
) (
   input wire logic aclk, // system clock
   input wire logic line_in, // device transmit pin
   output logic line_out // device receive pin
);
   timeunit 1ns;
   timeprecision 1ns;

   // receive pin driven only here
   // line rests at mark, no pull-down anywhere
   initial line_out = 1'b1;

   // start, data lsb first, stop of chosen level
   task automatic send(input logic [8:0] d, input int n, input logic stop);
      for (int i = 0; i < n + 2; i++) begin
         @(posedge aclk);
         line_out <= (i == 0) ? 1'b0 : (i > n) ? stop : d[i - 1];
         repeat (BIT - 1) @(posedge aclk);
      end
      @(posedge aclk);
      line_out <= 1'b1;
   endtask

   // short low pulse that a receiver must drop as a false start
   task automatic glitch(input int len);
      @(posedge aclk);
      line_out <= 1'b0;
      repeat (len) @(posedge aclk);
      line_out <= 1'b1;
   endtask

   // mid-bit sampling; sampled on negedge to stay clear of updates
   task automatic recv(input logic inv, input int n, input int wait_max,
      output logic [8:0] d, output logic ok);
      int k;
      d = '0;
      ok = 1'b0;
      for (k = 0; k < wait_max && (line_in ^ inv) !== 1'b0; k++) @(negedge aclk);
      if (k == wait_max) return;
      repeat (BIT / 2) @(negedge aclk);
      if ((line_in ^ inv) !== 1'b0) return;
      for (int i = 0; i < n; i++) begin
         repeat (BIT) @(negedge aclk);
         d[i] = line_in ^ inv;
      end
      repeat (BIT) @(negedge aclk);
      ok = (line_in ^ inv) === 1'b1;
   endtask
endmodule // serial_remote
`default_nettype wire

//--- async_serial_transceiver_tb.sv
// async_serial_transceiver_tb: register-level tests of transmit, receive,
// overrun and disable. assumes the design files and serial_remote compiled.
`include "serial_consts.svh"
`default_nettype none
module async_serial_transceiver_tb;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int bit_t = 64; // divisor 3: tick every 4 clocks
   localparam logic [7:0] a_ctrl = {`IDX_CTRL, 2'b00};
   localparam logic [7:0] a_stat = {`IDX_STAT, 2'b00};
   localparam logic [7:0] a_txd = {`IDX_TXD, 2'b00};
   localparam logic [7:0] a_rxd = {`IDX_RXD, 2'b00};
   localparam logic [7:0] a_baud = {`IDX_BAUD, 2'b00};
   localparam logic [31:0] b_en = 32'h1 << `CB_PORT_EN;
   localparam logic [31:0] b_tx = 32'h1 << `CB_TX_EN;
   localparam logic [31:0] b_rx = 32'h1 << `CB_RX_EN;
   localparam logic [31:0] b_sync = 32'h1 << `CB_SYNC;
   localparam logic [31:0] b_t9 = 32'h1 << `CB_TX_NINE;
   localparam logic [31:0] b_r9 = 32'h1 << `CB_RX9;
   localparam logic [31:0] b_inv = 32'h1 << `CB_INV;
   localparam logic [31:0] b_t9d = 32'h1 << `CB_TX_NINTH;
   localparam logic [31:0] s_tbe = 32'h1 << `SB_TBE;
   localparam logic [31:0] s_she = 32'h1 << `SB_SHE;
   localparam logic [31:0] s_pend = 32'h1 << `SB_PEND;
   localparam logic [31:0] s_ovr = 32'h1 << `SB_OVR;
   localparam logic [31:0] s_frm = 32'h1 << `SB_FRM_ERR;
   localparam logic [31:0] s_r9 = 32'h1 << `SB_RX9D;
   logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
   logic arvalid, arready, rvalid, rready, tx_out, tx_oe, rx_in, ok;
   logic [7:0] awaddr, araddr;
   logic [31:0] wdata, rdata, r;
   logic [3:0] wstrb;
   logic [1:0] bresp, rresp, rsp;
   logic [8:0] d9;
   int miscompares, checks;

   async_serial_transceiver dut (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid),
      .awready(awready), .awaddr(awaddr), .wvalid(wvalid), .wready(wready),
      .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid), .bready(bready), .bresp(bresp),
      .arvalid(arvalid), .arready(arready), .araddr(araddr), .rvalid(rvalid),
      .rready(rready), .rdata(rdata), .rresp(rresp), .tx_out(tx_out), .tx_oe(tx_oe),
      .rx_in(rx_in));
   serial_remote #(.BIT(bit_t)) far (.aclk(aclk), .line_in(tx_out), .line_out(rx_in));

   // 50 mhz clock
   always #10 aclk = ~aclk;

   task automatic complete_run;
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   task automatic hang;
      miscompares++;
      $display("[ERR] %0t no bus response", $time);
      complete_run;
   endtask

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   // ready sampled on the negedge before the edge that takes the item
   task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] q);
      logic ta, tw, hb;
      int n;
      @(posedge aclk);
      awvalid <= 1'b1;
      awaddr <= a;
      wvalid <= 1'b1;
      wdata <= d;
      wstrb <= 4'hf;
      bready <= 1'b1;
      for (n = 0; n < 100; n++) begin
         @(negedge aclk);
         ta = awvalid && awready;
         tw = wvalid && wready;
         hb = bvalid;
         q = bresp;
         @(posedge aclk);
         if (ta) awvalid <= 1'b0;
         if (tw) wvalid <= 1'b0;
         if (hb) break;
      end
      bready <= 1'b0;
      if (n == 100) hang;
   endtask

   task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] q);
      logic ta, hr;
      int n;
      @(posedge aclk);
      arvalid <= 1'b1;
      araddr <= a;
      rready <= 1'b1;
      for (n = 0; n < 100; n++) begin
         @(negedge aclk);
         ta = arvalid && arready;
         hr = rvalid;
         d = rdata;
         q = rresp;
         @(posedge aclk);
         if (ta) arvalid <= 1'b0;
         if (hr) break;
      end
      rready <= 1'b0;
      if (n == 100) hang;
   endtask

   task automatic sts(input logic [31:0] m, input logic [31:0] e);
      logic [31:0] v;
      logic [1:0] q;
      rd(a_stat, v, q);
      chk(v & m, e);
   endtask

   // main sequence: reset, registers, transmit, receive, overrun, disable
   initial begin
      aclk = 1'b0;
      aresetn = 1'b0;
      {awvalid, wvalid, bready, arvalid, rready} = '0;
      {awaddr, araddr, wdata, wstrb} = '0;
      miscompares = 0;
      checks = 0;
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      @(negedge aclk);
      chk(tx_out, 1);
      chk(tx_oe, 0);
      rd(a_ctrl, r, rsp);
      chk(r, 0);
      rd(a_baud, r, rsp);
      chk(r, `DIV_RST);
      rd(8'h40, r, rsp);
      chk(rsp, `RESP_ERR);
      wr(8'h40, 32'h0, rsp);
      chk(rsp, `RESP_ERR);
      // divisor before enables; high byte ignored while the narrow divisor is chosen
      wr(a_baud, 32'h103, rsp);
      chk(rsp, `RESP_OK);
      rd(a_baud, r, rsp);
      chk(r, 32'h103);
      wr(a_ctrl, b_en | b_sync | b_tx, rsp);
      chk(tx_oe, 1);
      wr(a_txd, 32'h55, rsp);
      repeat (bit_t) @(posedge aclk);
      chk(tx_out, 1);
      sts(s_she, s_she);
      wr(a_ctrl, b_en | b_tx, rsp);
      sts(s_tbe | s_she, s_tbe | s_she);
      // two writes back to back; the second waits in the buffer
      fork
         begin
            far.recv(1'b0, 8, 4 * bit_t, d9, ok);
            chk(d9, 9'h0a5);
            far.recv(1'b0, 8, bit_t, d9, ok);
            chk(d9, 9'h03c);
            chk(ok, 1);
         end
         begin
            wr(a_txd, 32'ha5, rsp);
            wr(a_txd, 32'h3c, rsp);
            sts(s_tbe | s_she, 0);
         end
      join
      repeat (bit_t) @(posedge aclk);
      sts(s_tbe | s_she, s_tbe | s_she);
      // ninth bit set before the data write
      wr(a_ctrl, b_en | b_tx | b_t9 | b_inv | b_t9d, rsp);
      @(negedge aclk);
      chk(tx_out, 0);
      fork
         far.recv(1'b1, 9, 4 * bit_t, d9, ok);
         wr(a_txd, 32'h5a, rsp);
      join
      chk(d9, 9'h15a);
      chk(ok, 1);
      repeat (bit_t) @(posedge aclk);
      wr(a_ctrl, b_en, rsp);
      far.send(9'h081, 8, 1'b1);
      sts(s_pend, 0);
      wr(a_ctrl, b_en | b_rx, rsp);
      far.glitch(bit_t / 4);
      repeat (bit_t) @(posedge aclk);
      sts(s_pend, 0);
      far.send(9'h081, 8, 1'b1);
      sts(s_pend | s_frm, s_pend);
      far.send(9'h0c3, 8, 1'b0);
      rd(a_rxd, r, rsp);
      chk(r[7:0], 8'h81);
      sts(s_pend | s_frm, s_pend | s_frm);
      rd(a_rxd, r, rsp);
      chk(r[7:0], 8'hc3);
      sts(s_pend, 0);
      // nine-bit reception carries the ninth bit in status
      wr(a_ctrl, b_en | b_rx | b_r9, rsp);
      far.send(9'h1a5, 9, 1'b1);
      sts(s_pend | s_r9, s_pend | s_r9);
      rd(a_rxd, r, rsp);
      chk(r[7:0], 8'ha5);
      wr(a_ctrl, b_en | b_rx, rsp);
      // four characters unread: the third overruns, the fourth is lost
      for (int i = 1; i < 5; i++) far.send(9'(8'h11 * i), 8, 1'b1);
      sts(s_ovr | s_pend, s_ovr | s_pend);
      rd(a_rxd, r, rsp);
      chk(r[7:0], 8'h11);
      rd(a_rxd, r, rsp);
      chk(r[7:0], 8'h22);
      sts(s_pend | s_ovr, s_ovr);
      wr(a_ctrl, b_en, rsp);
      sts(s_ovr, 0);
      wr(a_ctrl, b_en | b_rx, rsp);
      far.send(9'h0f0, 8, 1'b0);
      wr(a_ctrl, 32'h0, rsp);
      chk(tx_oe, 0);
      wr(a_ctrl, b_en | b_rx, rsp);
      sts(s_pend | s_frm | s_ovr, 0);
      complete_run;
   end
endmodule // async_serial_transceiver_tb
`default_nettype wire
